// *** core/alu_datapath_map.svh ***
// constants for the execution datapath
`ifndef ALU_DATAPATH_MAP_SVH
`define ALU_DATAPATH_MAP_SVH
`define DP_XOR_PAIR      8'h02
`define DP_FLS_NONE      16'h8000
`define DP_MISPRED_STALL 2'h2
`define DP_BRANCH_SKIP   3'h4
`define DP_EXT_HI_MSB    19
`define DP_EXT_HI_LSB    16
`define DP_SHIFT_DIR_BIT 4
`define DP_BYTE_REG      6'h38
`define DP_CRC_BASE_RST  20'h00000
`endif

// *** core/alu_datapath_pkg.sv ***
// types for the execution datapath
`default_nettype none
package alu_datapath_pkg;
  typedef enum logic [4:0] {
    OP_ADD      = 5'h00,
    OP_SUB      = 5'h01,
    OP_AND      = 5'h02,
    OP_OR       = 5'h03,
    OP_XOR      = 5'h04,
    OP_SHIFT    = 5'h05,
    OP_SHIFT_AR = 5'h06,
    OP_ROTATE   = 5'h07,
    OP_CMP      = 5'h08,
    OP_CMP_CHN  = 5'h09,
    OP_FLS      = 5'h0a,
    OP_LOAD_IMMEDIATE     = 5'h0b,
    OP_MAX      = 5'h0c,
    OP_MIN      = 5'h0d,
    OP_LD       = 5'h0e,
    OP_LDD      = 5'h0f,
    OP_ST       = 5'h10,
    OP_STD      = 5'h11,
    OP_BLOAD    = 5'h12,
    OP_HWSTORE  = 5'h13,
    OP_SRH      = 5'h14
  } opcode_t;
  typedef enum logic [2:0] {
    MOD_NONE = 3'h0,
    MOD_4    = 3'h1,
    MOD_8    = 3'h2,
    MOD_16   = 3'h3,
    MOD_32   = 3'h4,
    MOD_64   = 3'h5,
    MOD_128  = 3'h6,
    MOD_256  = 3'h7
  } modulo_t;
  typedef enum logic [2:0] {
    BR_NONE = 3'h0,
    BR_ZERO = 3'h1,
    BR_NNEG = 3'h2,
    BR_GT   = 3'h3,
    BR_GE   = 3'h4
  } branch_t;
  typedef enum logic [1:0] {
    CMP_EQ = 2'h0,
    CMP_GT = 2'h1,
    CMP_LT = 2'h2
  } cmp_res_t;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_BLOAD = 2'h1,
    ST_STALL = 2'h2,
    ST_DBL   = 2'h3
  } state_t;
endpackage
`default_nettype wire

// *** core/shift_unit.sv ***
// barrel shifter: logical, arithmetic right and rotate left
`timescale 1ns/1ps
`default_nettype none
`include "alu_datapath_map.svh"
module shift_unit #(
  parameter int WIDTH = 16
) (
  input  wire logic [WIDTH-1:0] operand,
  input  wire logic [4:0]       amount,
  input  wire logic             arith,
  input  wire logic             rotate,
  output logic      [WIDTH-1:0] result
);
  if (WIDTH != 16) begin : g_width_check
    $error("shift_unit serves 16 bits only");
  end
  logic [4:0]         mag;
  logic [2*WIDTH-1:0] dbl;
  logic [WIDTH-1:0]   fill;
  always_comb begin
    mag  = 5'h00;
    dbl  = {operand, operand};
    fill = {WIDTH{operand[WIDTH-1]}};
    if (rotate) begin
      dbl    = {operand, operand} << amount[3:0];
      result = dbl[2*WIDTH-1:WIDTH];
    end else if (arith) begin
      result = (operand >> amount[3:0]) |
               ~(fill >> amount[3:0]) & fill;
    end else if (amount[`DP_SHIFT_DIR_BIT]) begin
      mag    = 5'(~amount + 5'h01);
      result = operand >> mag;
    end else begin
      result = operand << amount[3:0];
    end
  end
endmodule
`default_nettype wire

// *** core/risc_alu_datapath.sv ***
// execution datapath: alu, shifts, compares, ram and fast-memory moves
//
// Operation
// - block load fills consecutive registers; address {rA[3:0],rB}
// - link option records register-to-location links for later write-back
// - halfword store writes byte register to address in two registers
// - result-halfword store writes to crc base plus byte offset
// - ram address is base plus index with index bit zero dropped
// - load double fills rd from addr and rd+1 from addr xor 2
// - store double writes rd at addr and rsb at addr xor 2
// - update-memory option writes result to destination's linked location
// - branch-if-zero jumps four slots; miss costs a two-cycle stall
// - modulo keeps high bits of source a; zero branch tests low bits
// - general shift: amount bits 4..0, sign gives direction, zero fill
// - right shift amount is two's-complement magnitude of the field
// - shifts leave the overflow flag untouched
// - rotate left by low four bits, direction bit ignored
// - arithmetic shift right by low four bits, sign filled
// - immediate shifts decode the amount field like register form
// - chained greater compare: prior gt takes, lt not, eq decides
// - compare without branch keeps its outcome for chaining
// - find-last-set gives top set index, or 0x8000 when none
// - nonnegative branch taken only when signed result is >= 0
// - load immediate loads the full sixteen-bit value
// - max and min compare unsigned operands
// - modulo arithmetic leaves the overflow flag untouched
`timescale 1ns/1ps
`default_nettype none
`include "alu_datapath_map.svh"
module risc_alu_datapath
  import alu_datapath_pkg::*;
#(
  parameter int NREG  = 64,
  parameter int RAMAW = 16
) (
  input  wire logic                     clock,
  input  wire logic                     sys_rst,
  input  wire logic                     instValid,
  output logic                          instReady,
  input  wire alu_datapath_pkg::opcode_t  opcode,
  input  wire alu_datapath_pkg::modulo_t  modulo,
  input  wire alu_datapath_pkg::branch_t  branchCond,
  input  wire logic                     immSel,
  input  wire logic [15:0]              immValue,
  input  wire logic                     linkOpt,
  input  wire logic                     updateMemOpt,
  input  wire logic [5:0]               srcA,
  input  wire logic [5:0]               srcB,
  input  wire logic [5:0]               dest,
  input  wire logic [7:0]               byteIndex,
  input  wire logic [4:0]               burstCount,
  input  wire logic [19:0]              crcBase,
  input  wire logic                     crcBaseLoad,
  output logic                          branchTaken,
  output logic                          stallOut,
  output logic                          overflowFlag,
  output logic                          ramWe,
  output logic [RAMAW-1:0]              ramAddr,
  output logic [15:0]                   ramWdata,
  input  wire logic [15:0]              ramRdata,
  output logic                          fmReq,
  output logic                          fmWe,
  output logic [19:0]                   fmAddr,
  output logic [15:0]                   fmWdata,
  input  wire logic                     fmAck,
  input  wire logic [15:0]              fmRdata,
  input  wire logic [5:0]               readSel,
  output logic [15:0]                   readData
);
  if (NREG != 64 || RAMAW > 16) begin : g_size_check
    $error("unsupported datapath sizes");
  end
  //////////////////////////////////////////////////////////////////////////
  // register file, links and state
  logic [15:0] regs_r  [NREG];
  logic [19:0] linkAdr_r [NREG];
  logic        linked_r [NREG];
  logic [19:0] crcBase_r;
  cmp_res_t    cmpPrev_r;
  state_t      state_r;
  logic [1:0]  stallCnt_r;
  logic [4:0]  burstLeft_r;
  logic [5:0]  burstReg_r;
  logic [19:0] burstAdr_r;
  logic        burstLink_r;
  logic [5:0]  dblReg_r;
  logic        ovf_r;
  logic [15:0] a;
  logic [15:0] b;
  logic [15:0] aluRes;
  logic [15:0] shiftRes;
  logic [15:0] finalRes;
  logic [15:0] lowMask;
  logic [16:0] sum;
  logic        ovfNxt;
  logic        writesReg;
  logic        isShift;
  logic        isCmp;
  cmp_res_t    cmpNow;
  logic        takeNxt;
  logic [15:0] ramBase;
  logic [15:0] ramAdrFull;
  logic        accept;
  logic [15:0] flsRes;
  assign a = regs_r[srcA];
  assign b = immSel ? immValue : regs_r[srcB];
  assign instReady = (state_r == ST_IDLE);
  assign accept = instValid && instReady;
  assign stallOut = !instReady;
  assign overflowFlag = ovf_r;
  assign readData = regs_r[readSel];
  //////////////////////////////////////////////////////////////////////////
  // shifter
  assign isShift = (opcode == OP_SHIFT) || (opcode == OP_SHIFT_AR) ||
                   (opcode == OP_ROTATE);
  shift_unit #(
    .WIDTH (16)
  ) u_shift (
    .operand (a),
    .amount  (b[4:0]),
    .arith   (opcode == OP_SHIFT_AR),
    .rotate  (opcode == OP_ROTATE),
    .result  (shiftRes)
  );
  //////////////////////////////////////////////////////////////////////////
  // alu
  always_comb begin
    flsRes = `DP_FLS_NONE;
    for (int i = 0; i < 16; i++) begin
      if (a[i]) flsRes = 16'(i);
    end
  end
  always_comb begin
    sum    = 17'h00000;
    ovfNxt = ovf_r;
    aluRes = 16'h0000;
    case (opcode)
      OP_ADD: begin
        sum    = {1'b0, a} + {1'b0, b};
        aluRes = sum[15:0];
        ovfNxt = (a[15] == b[15]) && (aluRes[15] != a[15]);
      end
      OP_SUB: begin
        sum    = {1'b0, a} - {1'b0, b};
        aluRes = sum[15:0];
        ovfNxt = (a[15] != b[15]) && (aluRes[15] != a[15]);
      end
      OP_AND:     aluRes = a & b;
      OP_OR:      aluRes = a | b;
      OP_XOR:     aluRes = a ^ b;
      OP_SHIFT, OP_SHIFT_AR, OP_ROTATE: begin
        aluRes = shiftRes;
        ovfNxt = ovf_r;
      end
      OP_FLS:     aluRes = flsRes;
      OP_LOAD_IMMEDIATE:    aluRes = immValue;
      OP_MAX:     aluRes = (a > b) ? a : b;
      OP_MIN:     aluRes = (a < b) ? a : b;
      OP_CMP, OP_CMP_CHN: aluRes = a - b;
      default:    aluRes = 16'h0000;
    endcase
    if (modulo != MOD_NONE) ovfNxt = ovf_r;
  end
  always_comb begin
    lowMask = 16'hffff;
    case (modulo)
      MOD_NONE: lowMask = 16'hffff;
      MOD_4:    lowMask = 16'h0003;
      MOD_8:    lowMask = 16'h0007;
      MOD_16:   lowMask = 16'h000f;
      MOD_32:   lowMask = 16'h001f;
      MOD_64:   lowMask = 16'h003f;
      MOD_128:  lowMask = 16'h007f;
      MOD_256:  lowMask = 16'h00ff;
      default:  lowMask = 16'hffff;
    endcase
  end
  assign finalRes = (aluRes & lowMask) | (a & ~lowMask);
  //////////////////////////////////////////////////////////////////////////
  // compare and branch decision
  assign isCmp = (opcode == OP_CMP) || (opcode == OP_CMP_CHN);
  assign cmpNow = (a > b) ? CMP_GT : ((a < b) ? CMP_LT : CMP_EQ);
  always_comb begin
    logic gtD;
    logic geD;
    gtD = (cmpNow == CMP_GT);
    geD = (cmpNow != CMP_LT);
    if (opcode == OP_CMP_CHN && cmpPrev_r != CMP_EQ) begin
      gtD = (cmpPrev_r == CMP_GT);
      geD = gtD;
    end
    case (branchCond)
      BR_ZERO: takeNxt = ((aluRes & lowMask) == 16'h0000);
      BR_NNEG: takeNxt = !finalRes[15];
      BR_GT:   takeNxt = isCmp && gtD;
      BR_GE:   takeNxt = isCmp && geD;
      default: takeNxt = 1'b0;
    endcase
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cmpPrev_r <= CMP_EQ;
    end else if (accept && isCmp) begin
      if (opcode == OP_CMP_CHN && cmpPrev_r != CMP_EQ) begin
        cmpPrev_r <= cmpPrev_r;
      end else begin
        cmpPrev_r <= cmpNow;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      branchTaken <= 1'b0;
    end else begin
      branchTaken <= accept && (branchCond != BR_NONE) && takeNxt;
    end
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ovf_r <= 1'b0;
    end else if (accept && !isShift) begin
      ovf_r <= ovfNxt;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // internal ram
  assign ramBase = regs_r[srcA] + {8'h00, byteIndex[7:1], 1'b0};
  assign writesReg = !isCmp && (opcode != OP_ST) && (opcode != OP_STD) &&
                     (opcode != OP_HWSTORE) && (opcode != OP_SRH) &&
                     (opcode != OP_BLOAD) && (opcode != OP_LD) &&
                     (opcode != OP_LDD);
  always_comb begin
    ramAdrFull = ramBase;
    ramWe      = 1'b0;
    ramWdata   = regs_r[dest];
    if (state_r == ST_DBL) begin
      ramAdrFull = ramBase ^ {8'h00, `DP_XOR_PAIR};
      ramWe      = (opcode == OP_STD);
      ramWdata   = regs_r[srcB];
    end else if (accept) begin
      ramWe = (opcode == OP_ST) || (opcode == OP_STD);
    end
  end
  assign ramAddr = ramAdrFull[RAMAW-1:0];
  //////////////////////////////////////////////////////////////////////////
  // fast memory requests
  always_comb begin
    fmReq   = 1'b0;
    fmWe    = 1'b0;
    fmAddr  = burstAdr_r;
    fmWdata = finalRes;
    if (state_r == ST_BLOAD) begin
      fmReq = 1'b1;
    end else if (accept) begin
      case (opcode)
        OP_HWSTORE: begin
          fmReq   = 1'b1;
          fmWe    = 1'b1;
          fmAddr  = {regs_r[srcA][3:0], regs_r[srcB]};
          fmWdata = regs_r[`DP_BYTE_REG];
        end
        OP_SRH: begin
          fmReq   = 1'b1;
          fmWe    = 1'b1;
          fmAddr  = crcBase_r + {12'h000, byteIndex};
          fmWdata = regs_r[srcA];
        end
        default: begin
          fmReq  = updateMemOpt && writesReg && linked_r[dest];
          fmWe   = fmReq;
          fmAddr = linkAdr_r[dest];
        end
      endcase
    end
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      crcBase_r <= `DP_CRC_BASE_RST;
    end else if (crcBaseLoad) begin
      crcBase_r <= crcBase;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // sequencing
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_r     <= ST_IDLE;
      stallCnt_r  <= 2'h0;
      burstLeft_r <= 5'h00;
      burstReg_r  <= 6'h00;
      burstAdr_r  <= 20'h00000;
      burstLink_r <= 1'b0;
      dblReg_r    <= 6'h00;
    end else begin
      case (state_r)
        ST_IDLE: if (accept) begin
          if (opcode == OP_BLOAD && burstCount != 5'h00) begin
            state_r     <= ST_BLOAD;
            burstLeft_r <= burstCount;
            burstReg_r  <= dest;
            burstAdr_r  <= {regs_r[srcA][3:0], regs_r[srcB]};
            burstLink_r <= linkOpt;
          end else if (opcode == OP_LDD || opcode == OP_STD) begin
            state_r  <= ST_DBL;
            dblReg_r <= dest + 6'h01;
          end else if (branchCond == BR_ZERO && !takeNxt) begin
            state_r    <= ST_STALL;
            stallCnt_r <= `DP_MISPRED_STALL - 2'h1;
          end
        end
        ST_BLOAD: if (fmAck) begin
          burstReg_r  <= burstReg_r + 6'h01;
          burstAdr_r  <= burstAdr_r + 20'h00002;
          burstLeft_r <= burstLeft_r - 5'h01;
          if (burstLeft_r == 5'h01) state_r <= ST_IDLE;
        end
        ST_STALL: begin
          if (stallCnt_r == 2'h0) state_r <= ST_IDLE;
          else stallCnt_r <= stallCnt_r - 2'h1;
        end
        ST_DBL: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // register and link write-back
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int i = 0; i < NREG; i++) begin
        regs_r[i]    <= 16'h0000;
        linkAdr_r[i] <= 20'h00000;
        linked_r[i]  <= 1'b0;
      end
    end else begin
      if (state_r == ST_BLOAD && fmAck) begin
        regs_r[burstReg_r]  <= fmRdata;
        linked_r[burstReg_r] <= burstLink_r;
        linkAdr_r[burstReg_r] <= burstAdr_r;
      end else if (state_r == ST_DBL && opcode == OP_LDD) begin
        regs_r[dblReg_r] <= ramRdata;
      end else if (accept && (opcode == OP_LD || opcode == OP_LDD)) begin
        regs_r[dest] <= ramRdata;
      end else if (accept && writesReg) begin
        regs_r[dest] <= finalRes;
      end
    end
  end
endmodule
`default_nettype wire

// *** testbench/dp_mem_model.sv ***
// partner model: internal ram and fast memory with adjustable ack delay
`timescale 1ns/1ps
`default_nettype none
module dp_mem_model (
  input  wire logic        clock,
  input  wire logic [1:0]  lat,
  input  wire logic        ramWe,
  input  wire logic [15:0] ramAddr,
  input  wire logic [15:0] ramWdata,
  output logic      [15:0] ramRdata,
  input  wire logic        fmReq,
  input  wire logic        fmWe,
  input  wire logic [19:0] fmAddr,
  input  wire logic [15:0] fmWdata,
  output logic             fmAck,
  output logic      [15:0] fmRdata
);
  logic [15:0] ram [512];
  logic [15:0] fm [2048];
  logic [1:0]  waitCnt_r = 2'h0;
  logic [10:0] fmIdx;
  ////////////////////////////////////////////////////////////////////////
  // byte-indexed ram: an odd address lands in a different word
  assign ramRdata = ram[ramAddr[8:0]];
  assign fmIdx    = {fmAddr[19:16], fmAddr[7:1]};
  assign fmAck    = fmReq && (waitCnt_r >= lat);
  // data not acknowledged shows the inverse
  assign fmRdata  = fmAck ? fm[fmIdx] : ~fm[fmIdx];
  // plain always: the bench preloads fast memory before the run
  always @(posedge clock) begin
    waitCnt_r <= (fmReq && !fmAck) ? waitCnt_r + 2'h1 : 2'h0;
    if (ramWe)
      ram[ramAddr[8:0]] <= ramWdata;
    if (fmAck && fmWe)
      fm[fmIdx] <= fmWdata;
  end
endmodule
`default_nettype wire

// *** testbench/dp_properties.sv ***
// checker on the datapath ports
`timescale 1ns/1ps
`default_nettype none
module dp_checker
  import alu_datapath_pkg::*;
#(
  parameter int RAMAW = 16
) (
  input wire logic                      clock,
  input wire logic                      sys_rst,
  input wire logic                      instValid,
  input wire logic                      instReady,
  input wire alu_datapath_pkg::opcode_t opcode,
  input wire alu_datapath_pkg::modulo_t modulo,
  input wire alu_datapath_pkg::branch_t branchCond,
  input wire logic                      branchTaken,
  input wire logic                      stallOut,
  input wire logic                      overflowFlag,
  input wire logic                      ramWe,
  input wire logic [RAMAW-1:0]          ramAddr,
  input wire logic                      fmReq,
  input wire logic                      fmWe,
  input wire logic [19:0]               fmAddr,
  input wire logic                      fmAck
);
  logic acc;
  assign acc = instValid && instReady;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////
  property p_bzMiss;
    acc && opcode == OP_XOR && branchCond == BR_ZERO ##1 !branchTaken
      |-> stallOut ##1 stallOut ##1 !stallOut;
  endproperty
  a_bzMiss: assert property (p_bzMiss)
    else $error("missed branch stall wrong");
  property p_bzHit;
    acc && opcode == OP_XOR && branchCond == BR_ZERO ##1 branchTaken
      |-> !stallOut;
  endproperty
  a_bzHit: assert property (p_bzHit)
    else $error("taken branch stalled");
  property p_brPulse;
    branchTaken |-> $past(acc);
  endproperty
  a_brPulse: assert property (p_brPulse)
    else $error("branch pulse without instruction");
  property p_lddPair;
    acc && opcode == OP_LDD
      |=> !instReady && (ramAddr ^ $past(ramAddr)) == RAMAW'(2);
  endproperty
  a_lddPair: assert property (p_lddPair)
    else $error("double load second address wrong");
  property p_stdPair;
    acc && opcode == OP_STD |-> ramWe
      ##1 (ramWe && (ramAddr ^ $past(ramAddr)) == RAMAW'(2));
  endproperty
  a_stdPair: assert property (p_stdPair)
    else $error("double store second write wrong");
  property p_bloadStep;
    fmReq && fmAck && !fmWe ##1 fmReq && !fmWe
      |-> fmAddr == $past(fmAddr) + 20'h2;
  endproperty
  a_bloadStep: assert property (p_bloadStep)
    else $error("block load address step wrong");
  property p_bloadBusy;
    fmReq && !fmWe |-> !instReady;
  endproperty
  a_bloadBusy: assert property (p_bloadBusy)
    else $error("ready during block load");
  property p_shiftOvf;
    acc && opcode inside {OP_SHIFT, OP_SHIFT_AR, OP_ROTATE}
      |=> $stable(overflowFlag);
  endproperty
  a_shiftOvf: assert property (p_shiftOvf)
    else $error("shift changed overflow");
  property p_modOvf;
    acc && modulo != MOD_NONE && opcode inside {OP_ADD, OP_SUB}
      |=> $stable(overflowFlag);
  endproperty
  a_modOvf: assert property (p_modOvf)
    else $error("modulo op changed overflow");
endmodule
bind risc_alu_datapath dp_checker #(.RAMAW(RAMAW)) chk (.clock, .sys_rst,
  .instValid, .instReady, .opcode, .modulo, .branchCond, .branchTaken,
  .stallOut, .overflowFlag, .ramWe, .ramAddr, .fmReq, .fmWe, .fmAddr,
  .fmAck);
`default_nettype wire

// *** testbench/risc_alu_shift_loadstore_datapath_bench.sv ***
// self-checking bench for the execution datapath
`timescale 1ns/1ps
`default_nettype none
module risc_alu_shift_loadstore_datapath_bench;
  import alu_datapath_pkg::*;
  logic        clock, sys_rst, instValid, instReady, immSel, linkOpt;
  logic        updateMemOpt, crcBaseLoad, branchTaken, stallOut, tk;
  logic        overflowFlag, ramWe, fmReq, fmWe, fmAck;
  opcode_t     opcode;
  modulo_t     modulo;
  branch_t     branchCond;
  logic [1:0]  lat;
  logic [4:0]  burstCount;
  logic [5:0]  srcA, srcB, dest, readSel;
  logic [7:0]  byteIndex;
  logic [15:0] immValue, ramAddr, ramWdata, ramRdata, fmWdata, fmRdata;
  logic [15:0] readData, msk;
  logic [19:0] crcBase, fmAddr;
  int          bad_count, n_tests;
  risc_alu_datapath uut (.clock, .sys_rst, .instValid, .instReady, .opcode,
    .modulo, .branchCond, .immSel, .immValue, .linkOpt, .updateMemOpt,
    .srcA, .srcB, .dest, .byteIndex, .burstCount, .crcBase, .crcBaseLoad,
    .branchTaken, .stallOut, .overflowFlag, .ramWe, .ramAddr, .ramWdata,
    .ramRdata, .fmReq, .fmWe, .fmAddr, .fmWdata, .fmAck, .fmRdata,
    .readSel, .readData);
  dp_mem_model mem (.clock, .lat, .ramWe, .ramAddr, .ramWdata, .ramRdata,
    .fmReq, .fmWe, .fmAddr, .fmWdata, .fmAck, .fmRdata);
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic reg_is(input logic [5:0] r, input logic [15:0] exp);
    readSel = r;
    #1 chk(readData, exp);
    @(negedge clock);
  endtask
  task automatic wait_rdy;
    for (int n = 0; n < 50 && instReady !== 1'b1; n++)
      @(negedge clock);
    if (instReady !== 1'b1) chk({15'h0, instReady}, 16'h0001);
  endtask
  // drive at a falling edge, hold to the accepting edge
  task automatic op(input opcode_t o, input logic [5:0] a, b, d,
    input logic [15:0] iv, input logic [7:0] bi, input modulo_t m,
    input branch_t br);
    opcode = o;
    {srcA, srcB, dest, immValue, byteIndex} = {a, b, d, iv, bi};
    modulo = m;
    branchCond = br;
    instValid = 1'b1;
    wait_rdy();
    @(negedge clock);
    instValid = 1'b0;
    tk = branchTaken;
    wait_rdy();
    @(negedge clock);
  endtask
  task automatic li(input logic [5:0] d, input logic [15:0] v);
    op(OP_LOAD_IMMEDIATE, 6'h0, 6'h0, d, v, 8'h0, MOD_NONE, BR_NONE);
  endtask
  task automatic alu(input opcode_t o, input logic [5:0] a, b, d,
    input branch_t br);
    op(o, a, b, d, 16'h0, 8'h0, MOD_NONE, br);
  endtask
  task automatic sh(input opcode_t o, input logic [15:0] a, amt,
    input logic im, input logic [15:0] exp);
    li(6'h02, a);
    li(6'h03, amt);
    immSel = im;
    op(o, 6'h02, 6'h03, 6'h04, amt, 8'h0, MOD_NONE, BR_NONE);
    immSel = 1'b0;
    reg_is(6'h04, exp);
  endtask
  task automatic find_last_set(input logic [15:0] a, exp, input logic t);
    li(6'h02, a);
    alu(OP_FLS, 6'h02, 6'h00, 6'h04, BR_NNEG);
    reg_is(6'h04, exp);
    chk({15'h0, tk}, {15'h0, t});
  endtask
  task automatic cc(input logic [5:0] a1, b1, a2, b2, input logic t);
    alu(OP_CMP, a1, b1, 6'h00, BR_NONE);
    alu(OP_CMP_CHN, a2, b2, 6'h00, BR_GT);
    chk({15'h0, tk}, {15'h0, t});
  endtask
  initial begin
    #100000;
    bad_count++;
    print_verdict();
  end
  initial begin
    sys_rst = 1'b1;
    {instValid, immSel, linkOpt, updateMemOpt, crcBaseLoad} = 5'h0;
    {srcA, srcB, dest, readSel, byteIndex, burstCount} = '0;
    {immValue, crcBase, lat} = '0;
    opcode = OP_ADD;
    modulo = MOD_NONE;
    branchCond = BR_NONE;
    for (int i = 0; i < 2048; i++)
      mem.fm[i] = 16'(i * 3 + 1);
    repeat (3) @(negedge clock);
    sys_rst = 1'b0;
    li(6'h01, 16'h67fc);
    reg_is(6'h01, 16'h67fc);
    li(6'h02, 16'h7fff);
    li(6'h03, 16'h0001);
    alu(OP_ADD, 6'h02, 6'h03, 6'h04, BR_NONE);
    chk({15'h0, overflowFlag}, 16'h0001);
    li(6'h02, 16'h1234);
    li(6'h03, 16'h00f0);
    for (int m = 1; m < 8; m++) begin
      msk = 16'((32'h4 << (m - 1)) - 1);
      op(OP_ADD, 6'h02, 6'h03, 6'h04, 16'h0, 8'h0, modulo_t'(m), BR_NONE);
      reg_is(6'h04, (16'h1234 & ~msk) | (16'h1324 & msk));
    end
    sh(OP_SHIFT, 16'hf234, 16'h0013, 1'b0, 16'h0007);
    sh(OP_SHIFT, 16'hf234, 16'h0003, 1'b0, 16'h91a0);
    sh(OP_SHIFT_AR, 16'h8234, 16'h0013, 1'b0, 16'hf046);
    sh(OP_ROTATE, 16'h8234, 16'h0013, 1'b0, 16'h11a4);
    sh(OP_SHIFT, 16'hf234, 16'h0019, 1'b1, 16'h01e4);
    sh(OP_SHIFT, 16'hf234, 16'h0007, 1'b1, 16'h1a00);
    chk({15'h0, overflowFlag}, 16'h0001);
    find_last_set(16'h8001, 16'h000f, 1'b1);
    find_last_set(16'h0001, 16'h0000, 1'b1);
    find_last_set(16'h0000, 16'h8000, 1'b0);
    li(6'h02, 16'h8000);
    alu(OP_MAX, 6'h02, 6'h03, 6'h04, BR_NONE);
    reg_is(6'h04, 16'h8000);
    alu(OP_MIN, 6'h02, 6'h03, 6'h04, BR_NONE);
    reg_is(6'h04, 16'h0007);
    li(6'h05, 16'h0005);
    li(6'h06, 16'h0009);
    cc(6'h05, 6'h06, 6'h06, 6'h05, 1'b0);
    cc(6'h05, 6'h05, 6'h06, 6'h05, 1'b1);
    cc(6'h06, 6'h05, 6'h05, 6'h06, 1'b1);
    alu(OP_CMP, 6'h05, 6'h05, 6'h00, BR_NONE);
    alu(OP_CMP_CHN, 6'h05, 6'h05, 6'h00, BR_GE);
    chk({15'h0, tk}, 16'h0001);
    alu(OP_SUB, 6'h05, 6'h06, 6'h04, BR_NNEG);
    reg_is(6'h04, 16'hfffc);
    chk({15'h0, tk}, 16'h0000);
    alu(OP_AND, 6'h05, 6'h06, 6'h04, BR_NONE);
    reg_is(6'h04, 16'h0001);
    alu(OP_OR, 6'h05, 6'h06, 6'h04, BR_NONE);
    reg_is(6'h04, 16'h000d);
    alu(OP_XOR, 6'h05, 6'h05, 6'h04, BR_ZERO);
    chk({15'h0, tk}, 16'h0001);
    alu(OP_XOR, 6'h05, 6'h06, 6'h04, BR_ZERO);
    chk({15'h0, tk}, 16'h0000);
    li(6'h02, 16'h1240);
    li(6'h03, 16'h00c0);
    op(OP_ADD, 6'h02, 6'h03, 6'h04, 16'h0, 8'h0, MOD_64, BR_ZERO);
    chk({15'h0, tk}, 16'h0001);
    li(6'h07, 16'h0100);
    op(OP_STD, 6'h07, 6'h06, 6'h05, 16'h0, 8'h0b, MOD_NONE, BR_NONE);
    chk(mem.ram[9'h10a], 16'h0005);
    chk(mem.ram[9'h108], 16'h0009);
    op(OP_LDD, 6'h07, 6'h00, 6'h0a, 16'h0, 8'h0b, MOD_NONE, BR_NONE);
    reg_is(6'h0a, 16'h0005);
    reg_is(6'h0b, 16'h0009);
    op(OP_ST, 6'h07, 6'h00, 6'h06, 16'h0, 8'h21, MOD_NONE, BR_NONE);
    chk(mem.ram[9'h120], 16'h0009);
    op(OP_LD, 6'h07, 6'h00, 6'h0c, 16'h0, 8'h09, MOD_NONE, BR_NONE);
    reg_is(6'h0c, 16'h0009);
    lat = 2'h2;
    li(6'h08, 16'h0003);
    li(6'h09, 16'h0040);
    burstCount = 5'h03;
    linkOpt = 1'b1;
    alu(OP_BLOAD, 6'h08, 6'h09, 6'h10, BR_NONE);
    linkOpt = 1'b0;
    for (int i = 0; i < 3; i++)
      reg_is(6'h10 + 6'(i), 16'((11'h1a0 + i) * 3 + 1));
    lat = 2'h0;
    updateMemOpt = 1'b1;
    alu(OP_ADD, 6'h05, 6'h06, 6'h11, BR_NONE);
    updateMemOpt = 1'b0;
    chk(mem.fm[11'h1a1], 16'h000e);
    li(6'h38, 16'hbeef);
    li(6'h09, 16'h0050);
    alu(OP_HWSTORE, 6'h08, 6'h09, 6'h00, BR_NONE);
    chk(mem.fm[11'h1a8], 16'hbeef);
    crcBase = 20'h30060;
    crcBaseLoad = 1'b1;
    @(negedge clock);
    crcBaseLoad = 1'b0;
    op(OP_SRH, 6'h05, 6'h00, 6'h00, 16'h0, 8'h0a, MOD_NONE, BR_NONE);
    chk(mem.fm[11'h1b5], 16'h0005);
    print_verdict();
  end
endmodule
`default_nettype wire
